/* File: rtl/ubk_user_break_unit.sv */
`timescale 1ns/10ps
module ubk_user_break_unit
    import ubk_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire ubk_cycle_s  cpu_cycle,
    input  wire logic [7:0]  page_entry_high_space_id,
    output logic             break_req,
    output logic             break_after,
    output logic             break_chan_b
);

    ubk_state_s state_reg;
    ubk_state_s state_next;

    // ------------------------------------------------------------
    // Channel comparison
    // ------------------------------------------------------------
    function automatic logic chan_match(
        input ubk_chan_s  ch,
        input ubk_cycle_s cy,
        input logic [7:0] sid
    );
        logic [31:0] amask;
        logic        addr_ok;
        logic        sid_ok;
        logic        type_ok;
        logic        dir_ok;
        logic        size_ok;
        amask = '1;
        unique case (ch.mask[1:0])  // see [R3]
            AMASK_NONE:  amask = '1;
            AMASK_LOW10: amask = LOW10_MASK;
            AMASK_LOW12: amask = LOW12_MASK;
            AMASK_ALL:   amask = '0;
        endcase
        addr_ok = ((ch.addr ^ cy.addr) & amask) == 32'h00000000;  // see [R2]
        sid_ok  = ch.mask[SPACE_ID_MASK_BIT] || (ch.space_id == sid);  // see [R4] see [R5]
        // A zero select field gives no match at all
        type_ok = cy.fetch ? ch.cycle[CYCLE_TYPE_LSB] : ch.cycle[CYCLE_TYPE_LSB+1];  // see [R6] see [R20]
        dir_ok  = cy.write ? ch.cycle[DIRECTION_LSB+1] : ch.cycle[DIRECTION_LSB];  // see [R7] see [R20]
        size_ok = (ch.cycle[SIZE_LSB+1:SIZE_LSB] == SIZE_ANY)
               || (ch.cycle[SIZE_LSB+1:SIZE_LSB] == cy.size);  // see [R8]
        return cy.valid && addr_ok && sid_ok && type_ok && dir_ok && size_ok;  // see [R19]
    endfunction

    logic        hit_a;
    logic        hit_b_cond;
    logic        data_ok;
    logic [31:0] data_cmp_mask;
    logic        hit_b;

    always_comb begin
        hit_a      = chan_match(state_reg.chan_a, cpu_cycle, page_entry_high_space_id);  // see [R1]
        hit_b_cond = chan_match(state_reg.chan_b, cpu_cycle, page_entry_high_space_id);  // see [R1]
        // Byte and word compare only the low half of the bus
        data_cmp_mask = ~state_reg.data_mask_b;
        if (cpu_cycle.size == SIZE_BYTE || cpu_cycle.size == SIZE_WORD) begin
            data_cmp_mask = data_cmp_mask & LOW16_ONLY;  // see [R18]
        end
        // Fetch cycles carry no operand, so data never gates them
        data_ok = !state_reg.data_compare_enable_b || cpu_cycle.fetch
               || (((cpu_cycle.data ^ state_reg.data_b) & data_cmp_mask) == 32'h00000000);  // see [R10]
        hit_b = hit_b_cond && data_ok;  // see [R19]
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    function automatic logic [31:0] read_value(input ubk_state_s s, input logic [31:0] a);
        logic [31:0] v;
        v = 32'h00000000;  // see [R16]
        unique case (a)
            ADDR_BREAK_ADDRESS_A:   v = s.chan_a.addr;
            ADDR_BREAK_ADDRESS_B:   v = s.chan_b.addr;
            ADDR_BREAK_SPACE_ID_A:  v = {24'h000000, s.chan_a.space_id};
            ADDR_BREAK_SPACE_ID_B:  v = {24'h000000, s.chan_b.space_id};
            ADDR_BREAK_ADDR_MASK_A: v = {29'h00000000, s.chan_a.mask};
            ADDR_BREAK_ADDR_MASK_B: v = {29'h00000000, s.chan_b.mask};
            ADDR_BREAK_CYCLE_A:     v = {26'h0000000, s.chan_a.cycle};
            ADDR_BREAK_CYCLE_B:     v = {26'h0000000, s.chan_b.cycle};
            ADDR_BREAK_DATA_B:      v = s.data_b;
            ADDR_BREAK_DATA_MASK_B: v = s.data_mask_b;
            ADDR_BREAK_CONTROL: begin
                v[CTL_MATCH_A_BIT]    = s.match_flag_a;
                v[CTL_MATCH_B_BIT]    = s.match_flag_b;
                v[CTL_AFTER_A_BIT]    = s.fetch_break_after_a;
                v[CTL_DATA_EN_BIT]    = s.data_compare_enable_b;
                v[CTL_AFTER_B_BIT]    = s.fetch_break_after_b;
                v[CTL_SEQUENTIAL_BIT] = s.sequential_channels;
            end
            default:                v = 32'h00000000;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic addr_phase;
    logic brk;
    logic set_a;
    logic set_b;

    always_comb begin
        state_next = state_reg;
        addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
        state_next.wr_pend   = addr_phase && hwrite;
        state_next.hreadyout = 1'b1;
        if (addr_phase) begin
            state_next.wr_addr = haddr;
        end

        // Register writes land in the data phase
        if (state_reg.wr_pend) begin
            unique case (state_reg.wr_addr)
                ADDR_BREAK_ADDRESS_A:   state_next.chan_a.addr     = hwdata;
                ADDR_BREAK_ADDRESS_B:   state_next.chan_b.addr     = hwdata;
                ADDR_BREAK_SPACE_ID_A:  state_next.chan_a.space_id = hwdata[7:0];
                ADDR_BREAK_SPACE_ID_B:  state_next.chan_b.space_id = hwdata[7:0];
                ADDR_BREAK_ADDR_MASK_A: state_next.chan_a.mask     = hwdata[2:0];  // see [R16]
                ADDR_BREAK_ADDR_MASK_B: state_next.chan_b.mask     = hwdata[2:0];  // see [R16]
                ADDR_BREAK_CYCLE_A:     state_next.chan_a.cycle    = hwdata[5:0];  // see [R16]
                ADDR_BREAK_CYCLE_B:     state_next.chan_b.cycle    = hwdata[5:0];  // see [R16]
                ADDR_BREAK_DATA_B:      state_next.data_b          = hwdata;
                ADDR_BREAK_DATA_MASK_B: state_next.data_mask_b     = hwdata;
                ADDR_BREAK_CONTROL: begin
                    state_next.match_flag_a          = hwdata[CTL_MATCH_A_BIT];  // see [R13]
                    state_next.match_flag_b          = hwdata[CTL_MATCH_B_BIT];  // see [R13]
                    state_next.fetch_break_after_a   = hwdata[CTL_AFTER_A_BIT];
                    state_next.data_compare_enable_b = hwdata[CTL_DATA_EN_BIT];
                    state_next.fetch_break_after_b   = hwdata[CTL_AFTER_B_BIT];
                    state_next.sequential_channels   = hwdata[CTL_SEQUENTIAL_BIT];
                    // Leaving sequential mode drops a half-finished sequence unless channel A hits in that same cycle
                    if (!hwdata[CTL_SEQUENTIAL_BIT]) begin
                        state_next.a_armed = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Break decision
        if (state_reg.sequential_channels) begin
            set_a = hit_a;
            set_b = hit_b && state_reg.a_armed;  // see [R11]
            brk   = set_b;
            if (hit_a) begin
                state_next.a_armed = 1'b1;
            end
            if (set_b) begin
                state_next.a_armed = 1'b0;
            end
        end else begin
            set_a = hit_a;
            set_b = hit_b;
            brk   = hit_a || hit_b;
        end

        // Hardware set wins over a software clear in the same cycle
        if (set_a) begin
            state_next.match_flag_a = 1'b1;  // see [R12]
        end
        if (set_b) begin
            state_next.match_flag_b = 1'b1;  // see [R12]
        end

        state_next.break_req    = brk;  // see [R17]
        state_next.break_chan_b = set_b;
        state_next.break_after  = brk && cpu_cycle.fetch
            && (set_b ? state_reg.fetch_break_after_b : state_reg.fetch_break_after_a);  // see [R9]

        // Read data sampled from the post-write view, so back to back works
        state_next.hrdata = 32'h00000000;
        if (addr_phase && !hwrite) begin
            state_next.hrdata = read_value(state_next, haddr);
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // No standby input: nothing here clears state except reset
    always_ff @(posedge hclk or negedge hresetn) begin  // see [R15]
        if (!hresetn) begin
            state_reg                       <= '0;  // see [R14]
            state_reg.chan_a.cycle          <= CYCLE_RESET;
            state_reg.chan_b.cycle          <= CYCLE_RESET;
            state_reg.match_flag_a          <= CTL_RESET[CTL_MATCH_A_BIT];
            state_reg.match_flag_b          <= CTL_RESET[CTL_MATCH_B_BIT];
            state_reg.fetch_break_after_a   <= CTL_RESET[CTL_AFTER_A_BIT];
            state_reg.fetch_break_after_b   <= CTL_RESET[CTL_AFTER_B_BIT];
            state_reg.data_compare_enable_b <= CTL_RESET[CTL_DATA_EN_BIT];
            state_reg.sequential_channels   <= CTL_RESET[CTL_SEQUENTIAL_BIT];
            state_reg.hreadyout             <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign hreadyout    = state_reg.hreadyout;
    assign hrdata       = state_reg.hrdata;
    assign hresp        = 1'b0;
    assign break_req    = state_reg.break_req;
    assign break_after  = state_reg.break_after;
    assign break_chan_b = state_reg.break_chan_b;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    flag_a_sticky_a: assert property (state_reg.match_flag_a && !state_reg.wr_pend
        |=> state_reg.match_flag_a)  // see [R12]
        else $error("match flag A dropped without a write");

    flag_b_set_a: assert property (!state_reg.sequential_channels && hit_b
        |=> state_reg.match_flag_b && break_req && break_chan_b)  // see [R12]
        else $error("channel B hit did not set flag and break");

    seq_needs_arm_a: assert property (state_reg.sequential_channels && !state_reg.a_armed && !hit_a
        ##1 !state_reg.a_armed |-> !break_req)  // see [R11]
        else $error("sequential break without channel A first");

    zero_type_a: assert property (state_reg.chan_a.cycle[5:4] == 2'h0 |-> !hit_a)  // see [R20]
        else $error("channel A matched with cycle type off");

    zero_dir_a: assert property (state_reg.chan_b.cycle[3:2] == 2'h0 |-> !hit_b)  // see [R20]
        else $error("channel B matched with direction off");

    addr_mask_a: assert property (hit_a && state_reg.chan_a.mask[1:0] == AMASK_NONE
        |-> cpu_cycle.addr == state_reg.chan_a.addr)  // see [R3]
        else $error("channel A matched a different address");

    space_id_a: assert property (hit_b_cond && !state_reg.chan_b.mask[SPACE_ID_MASK_BIT]
        |-> page_entry_high_space_id == state_reg.chan_b.space_id)  // see [R5]
        else $error("channel B matched a foreign space id");

    size_check_a: assert property (hit_a && state_reg.chan_a.cycle[1:0] != SIZE_ANY
        |-> cpu_cycle.size == state_reg.chan_a.cycle[1:0])  // see [R8]
        else $error("channel A matched a wrong size");

    after_sel_a: assert property (break_after |-> $past(cpu_cycle.fetch))  // see [R9]
        else $error("after-execution break on a non-fetch cycle");

    ctl_reset_a: assert property ($rose(hresetn) |-> hrdata == 32'h00000000 && !break_req)  // see [R14]
        else $error("outputs not clear after reset");

endmodule

/* File: rtl/ubk_pkg.sv */
// Functional notes
// [R1] Two channels A and B, separately evaluated
// [R2] 32-bit virtual break address per channel
// [R3] Address mask: all, low 10, low 12, none
// [R4] 8-bit identifier compared against current space id
// [R5] Identifier mask bit 2 excludes identifier
// [R6] Cycle type: none, fetch, data, either
// [R7] Direction: none, read, write, both
// [R8] Size: any, byte, word, longword
// [R9] Fetch break taken before or after execution
// [R10] Channel B masked data compare when enabled
// [R11] Sequential mode: B after A breaks
// [R12] Break sets match flags; never self-cleared
// [R13] Software clears flags before next break
// [R14] Reset clears cycle and control registers
// [R15] Registers retained in standby
// [R16] Reserved bits read zero, write zero
// [R17] Satisfied conditions raise user break trap
// [R18] Byte/word ignore data bits 31 to 16
// [R19] Match needs all enabled conditions together
// [R20] Cycle or direction 00 never matches
package ubk_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_BREAK_ADDRESS_A   = 32'h0fffffb0;
    localparam logic [31:0] ADDR_BREAK_ADDR_MASK_A = 32'h0fffffb4;
    localparam logic [31:0] ADDR_BREAK_CYCLE_A     = 32'h0fffffb8;
    localparam logic [31:0] ADDR_BREAK_DATA_B      = 32'hffffff90;
    localparam logic [31:0] ADDR_BREAK_DATA_MASK_B = 32'hffffff94;
    localparam logic [31:0] ADDR_BREAK_CONTROL     = 32'hffffff98;
    localparam logic [31:0] ADDR_BREAK_ADDRESS_B   = 32'hffffffa0;
    localparam logic [31:0] ADDR_BREAK_ADDR_MASK_B = 32'hffffffa4;
    localparam logic [31:0] ADDR_BREAK_CYCLE_B     = 32'hffffffa8;
    localparam logic [31:0] ADDR_BREAK_SPACE_ID_A  = 32'hffffffe4;
    localparam logic [31:0] ADDR_BREAK_SPACE_ID_B  = 32'hffffffe8;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int SPACE_ID_MASK_BIT  = 2;
    localparam int CYCLE_TYPE_LSB     = 4;
    localparam int DIRECTION_LSB      = 2;
    localparam int SIZE_LSB           = 0;
    localparam int CTL_MATCH_A_BIT    = 15;
    localparam int CTL_MATCH_B_BIT    = 14;
    localparam int CTL_AFTER_A_BIT    = 10;
    localparam int CTL_DATA_EN_BIT    = 7;
    localparam int CTL_AFTER_B_BIT    = 6;
    localparam int CTL_SEQUENTIAL_BIT = 3;

    localparam logic [1:0] AMASK_NONE  = 2'h0;
    localparam logic [1:0] AMASK_LOW10 = 2'h1;
    localparam logic [1:0] AMASK_LOW12 = 2'h2;
    localparam logic [1:0] AMASK_ALL   = 2'h3;
    localparam logic [1:0] SIZE_ANY    = 2'h0;
    localparam logic [1:0] SIZE_BYTE   = 2'h1;
    localparam logic [1:0] SIZE_WORD   = 2'h2;

    localparam logic [31:0] LOW10_MASK = 32'hfffffc00;
    localparam logic [31:0] LOW12_MASK = 32'hfffff000;
    localparam logic [31:0] LOW16_ONLY = 32'h0000ffff;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0]  CYCLE_RESET = 6'h00;
    localparam logic [15:0] CTL_RESET   = 16'h0000;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        fetch;
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] data;
    } ubk_cycle_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  space_id;
        logic [2:0]  mask;
        logic [5:0]  cycle;
    } ubk_chan_s;

    typedef struct packed {
        ubk_chan_s   chan_a;
        ubk_chan_s   chan_b;
        logic [31:0] data_b;
        logic [31:0] data_mask_b;
        logic        match_flag_a;
        logic        match_flag_b;
        logic        fetch_break_after_a;
        logic        fetch_break_after_b;
        logic        data_compare_enable_b;
        logic        sequential_channels;
        logic        a_armed;
        logic        wr_pend;
        logic [31:0] wr_addr;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        break_req;
        logic        break_after;
        logic        break_chan_b;
    } ubk_state_s;

endpackage

/* File: verification/ubk_cpu_model.sv */
`timescale 1ns/10ps
module ubk_cpu_model
    import ubk_pkg::*;
(
    input  wire logic  hclk,
    output ubk_cycle_s cyc,
    output logic [7:0] space_id
);
    initial begin
        cyc      = '0;
        space_id = 8'h00;
    end

    // One bus cycle per call; afterwards the lines show a stale, inverted pattern
    task automatic issue(input logic f, input logic w, input logic [1:0] sz, input logic [31:0] a,
                         input logic [31:0] d, input logic [7:0] sid);
        cyc      <= {1'b1, f, w, sz, a, d};
        space_id <= sid;
        @(posedge hclk);
        cyc      <= {1'b0, ~f, ~w, ~sz, ~a, ~d};
        space_id <= ~sid;
    endtask
endmodule

/* File: verification/tb_two_channel_break_comparator.sv */
`timescale 1ns/10ps
module tb_two_channel_break_comparator;
    import ubk_pkg::*;
    localparam logic [31:0] A_ADDR = 32'h12345678;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        break_req, break_after, break_chan_b;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  space_id;
    ubk_cycle_s  cpu_cycle;
    int          err_count, num_checks;

    ubk_user_break_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .cpu_cycle(cpu_cycle), .page_entry_high_space_id(space_id),
        .break_req(break_req), .break_after(break_after), .break_chan_b(break_chan_b));
    ubk_cpu_model cpu (.hclk(hclk), .cyc(cpu_cycle), .space_id(space_id));

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // No fixed latency assumed: both phases wait for hready
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp, "register read");
        chk({31'h0, hresp}, 32'h0, "response");
    endtask

    // Qualifiers must stay low when no break is requested
    task automatic hit(input logic f, input logic w, input logic [1:0] sz, input logic [31:0] a,
                       input logic [31:0] d, input logic [7:0] sid, input logic [2:0] exp);
        cpu.issue(f, w, sz, a, d, sid);
        @(posedge hclk);
        chk({29'h0, break_req, break_after, break_chan_b}, {29'h0, exp}, "break");
    endtask

    task automatic case_a(input logic [2:0] m, input logic [5:0] bb, input logic f, input logic w,
                          input logic [1:0] sz, input logic [31:0] ax, input logic [7:0] sid, input logic e);
        wr(ADDR_BREAK_ADDR_MASK_A, {29'h0, m});
        wr(ADDR_BREAK_CYCLE_A, {26'h0, bb});
        wr(ADDR_BREAK_CONTROL, 32'h0);
        hit(f, w, sz, A_ADDR ^ ax, 32'h0, sid, {e, 2'b00});
    endtask

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    initial begin
        #(20 * 6000);
        err_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        finish_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        err_count  = 0;
        num_checks = 0;
        hresetn    = 1'b0;
        hsel       = 1'b0;
        haddr      = 32'h0;
        htrans     = 2'h0;
        hwrite     = 1'b0;
        hsize      = 3'h2;
        hwdata     = 32'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(ADDR_BREAK_CYCLE_A, 32'h0);
        rdc(ADDR_BREAK_CYCLE_B, 32'h0);
        rdc(ADDR_BREAK_CONTROL, 32'h0);
        hit(1'b1, 1'b0, 2'h3, 32'h0, 32'h0, 8'h00, 3'b000);
        wr(ADDR_BREAK_CYCLE_A, 32'hffffffff);
        rdc(ADDR_BREAK_CYCLE_A, 32'h0000003f);
        wr(ADDR_BREAK_ADDR_MASK_B, 32'hffffffff);
        rdc(ADDR_BREAK_ADDR_MASK_B, 32'h00000007);
        wr(ADDR_BREAK_CONTROL, 32'hffffffff);
        rdc(ADDR_BREAK_CONTROL, 32'h0000c4c8);
        wr(32'h00000000, 32'hffffffff);
        rdc(32'h00000000, 32'h0);
        wr(ADDR_BREAK_ADDRESS_A, A_ADDR);
        rdc(ADDR_BREAK_ADDRESS_A, A_ADDR);
        wr(ADDR_BREAK_SPACE_ID_A, 32'h5a);
        rdc(ADDR_BREAK_SPACE_ID_A, 32'h5a);
        case_a(3'h7, 6'h30, 1'b1, 1'b0, 2'h3, 32'h0, 8'h5a, 1'b0);
        case_a(3'h7, 6'h0c, 1'b1, 1'b0, 2'h3, 32'h0, 8'h5a, 1'b0);
        case_a(3'h0, 6'h14, 1'b1, 1'b0, 2'h3, 32'h0, 8'h5a, 1'b1);
        repeat (5) @(posedge hclk);
        rdc(ADDR_BREAK_CONTROL, 32'h00008000);
        case_a(3'h0, 6'h14, 1'b1, 1'b0, 2'h3, 32'h1, 8'h5a, 1'b0);
        case_a(3'h1, 6'h14, 1'b1, 1'b0, 2'h3, 32'h3ff, 8'h5a, 1'b1);
        case_a(3'h1, 6'h14, 1'b1, 1'b0, 2'h3, 32'h400, 8'h5a, 1'b0);
        case_a(3'h2, 6'h14, 1'b1, 1'b0, 2'h3, 32'hfff, 8'h5a, 1'b1);
        case_a(3'h2, 6'h14, 1'b1, 1'b0, 2'h3, 32'h1000, 8'h5a, 1'b0);
        case_a(3'h3, 6'h14, 1'b1, 1'b0, 2'h3, 32'hffffffff, 8'h5a, 1'b1);
        case_a(3'h0, 6'h14, 1'b1, 1'b0, 2'h3, 32'h0, 8'ha5, 1'b0);
        case_a(3'h4, 6'h14, 1'b1, 1'b0, 2'h3, 32'h0, 8'ha5, 1'b1);
        case_a(3'h0, 6'h24, 1'b1, 1'b0, 2'h3, 32'h0, 8'h5a, 1'b0);
        case_a(3'h0, 6'h24, 1'b0, 1'b0, 2'h3, 32'h0, 8'h5a, 1'b1);
        case_a(3'h0, 6'h34, 1'b1, 1'b0, 2'h3, 32'h0, 8'h5a, 1'b1);
        case_a(3'h0, 6'h28, 1'b0, 1'b0, 2'h3, 32'h0, 8'h5a, 1'b0);
        case_a(3'h0, 6'h28, 1'b0, 1'b1, 2'h3, 32'h0, 8'h5a, 1'b1);
        case_a(3'h0, 6'h2c, 1'b0, 1'b1, 2'h3, 32'h0, 8'h5a, 1'b1);
        case_a(3'h0, 6'h25, 1'b0, 1'b0, 2'h1, 32'h0, 8'h5a, 1'b1);
        case_a(3'h0, 6'h25, 1'b0, 1'b0, 2'h2, 32'h0, 8'h5a, 1'b0);
        case_a(3'h0, 6'h26, 1'b0, 1'b0, 2'h2, 32'h0, 8'h5a, 1'b1);
        case_a(3'h0, 6'h27, 1'b0, 1'b0, 2'h3, 32'h0, 8'h5a, 1'b1);
        case_a(3'h0, 6'h27, 1'b0, 1'b0, 2'h2, 32'h0, 8'h5a, 1'b0);
        wr(ADDR_BREAK_CYCLE_A, 32'h14);
        wr(ADDR_BREAK_CONTROL, 32'h400);
        hit(1'b1, 1'b0, 2'h3, A_ADDR, 32'h0, 8'h5a, 3'b110);
        rdc(ADDR_BREAK_CONTROL, 32'h00008400);
        // Channel B: address and id ignored, data compared
        wr(ADDR_BREAK_CYCLE_A, 32'h0);
        wr(ADDR_BREAK_ADDR_MASK_B, 32'h7);
        wr(ADDR_BREAK_DATA_B, 32'h11223344);
        wr(ADDR_BREAK_DATA_MASK_B, 32'h000000ff);
        wr(ADDR_BREAK_CYCLE_B, 32'h2b);
        wr(ADDR_BREAK_CONTROL, 32'h80);
        hit(1'b0, 1'b1, 2'h3, 32'h0, 32'h112233aa, 8'h00, 3'b101);
        wr(ADDR_BREAK_CONTROL, 32'h80);
        hit(1'b0, 1'b1, 2'h3, 32'h0, 32'h11223244, 8'h00, 3'b000);
        wr(ADDR_BREAK_CYCLE_B, 32'h2a);
        hit(1'b0, 1'b1, 2'h2, 32'h0, 32'hffff3300, 8'h00, 3'b101);
        wr(ADDR_BREAK_CONTROL, 32'h0);
        hit(1'b0, 1'b1, 2'h2, 32'h0, 32'h0, 8'h00, 3'b101);
        // Sequential: B alone, then A arms, then B breaks
        wr(ADDR_BREAK_CYCLE_A, 32'h14);
        wr(ADDR_BREAK_CONTROL, 32'h08);
        hit(1'b0, 1'b1, 2'h2, 32'h0, 32'h0, 8'h00, 3'b000);
        hit(1'b1, 1'b0, 2'h3, A_ADDR, 32'h0, 8'h5a, 3'b000);
        hit(1'b0, 1'b1, 2'h2, 32'h0, 32'h0, 8'h00, 3'b101);
        rdc(ADDR_BREAK_CONTROL, 32'h0000c008);
        wr(ADDR_BREAK_CONTROL, 32'h0);
        rdc(ADDR_BREAK_CONTROL, 32'h0);
        finish_test();
    end
endmodule
